// >>> include/udsc_pkg.sv
package udsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [15:0] ADDR_RX_ERR_STATUS  = 16'hFF53;
  localparam logic [15:0] ADDR_TX_BUF_STATUS  = 16'hFF55;
  localparam logic [15:0] ADDR_BASE_CLK_SEL   = 16'hFF56;
  localparam logic [15:0] ADDR_ASYNC_RX_BUF   = 16'hFF52;
  localparam logic [15:0] ADDR_LIGHT_RX_BUF   = 16'hFF59;
  localparam logic [15:0] ADDR_TX_BUF         = 16'hFF54;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned BIT_MFE  = 7;
  localparam int unsigned BIT_PE   = 2;
  localparam int unsigned BIT_FE   = 1;
  localparam int unsigned BIT_OVE  = 0;
  localparam int unsigned BIT_TXBF = 1;
  localparam int unsigned BIT_TXSF = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [7:0] RST_RX_ERR_STATUS = 8'h00;
  localparam logic [7:0] RST_TX_BUF_STATUS = 8'h00;
  localparam logic [3:0] RST_BASE_CLK_SEL  = 4'h0;
  localparam logic [3:0] BCS_MAX_CODE      = 4'hA;
  localparam int unsigned PRESCALE_W       = 10;
  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD  = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;

  typedef enum logic [0:0] {
    UDSC_RD_IDLE = 1'b0,
    UDSC_RD_WAIT = 1'b1
  } udsc_rd_t;

endpackage

// >>> verilog/udsc_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none

module udsc_skid_buf #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic         out_valid_q;
  logic [W-1:0] out_data_q;
  logic         skid_valid_q;
  logic [W-1:0] skid_data_q;
  wire          push = in_valid && !skid_valid_q;
  wire          pop  = out_valid_q && out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Two entries: ready is a flop, so a stall never breaks a combinational path
  always_ff @(posedge clock) begin
    if (!rstn || flush) begin
      out_valid_q  <= 1'b0;
      skid_valid_q <= 1'b0;
      out_data_q   <= '0;
      skid_data_q  <= '0;
    end else begin
      if (!out_valid_q || pop) begin
        out_valid_q <= skid_valid_q || push;
        out_data_q  <= skid_valid_q ? skid_data_q : in_data;
        if (skid_valid_q) begin
          skid_valid_q <= push;
          skid_data_q  <= in_data;
        end
      end else if (push) begin
        skid_valid_q <= 1'b1;
        skid_data_q  <= in_data;
      end
    end
  end

  assign in_ready  = !skid_valid_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

endmodule // udsc_skid_buf

`default_nettype wire

// >>> verilog/udsc_status_clock.sv
// Operation
// - Error status clears to zero on reset, power off or receive disable.
// - Each error flag clears on status read and while power or receive is off.
// - Asynchronous mode: Manchester error flag reads zero.
// - Lighting mode: parity error flag reads zero.
// - Undecodable lighting symbol sets Manchester error, bit 7.
// - Parity mismatch on asynchronous completion sets bit 2, per parity mode.
// - Missing stop bit on completion sets framing error, bit 1.
// - Only the first stop bit is examined.
// - Completion with previous character unread sets overrun, bit 0.
// - On overrun the new character is dropped, buffers keep old content.
// - Status read takes one wait cycle; not while peripheral clock stopped.
// - Transmit status clears on reset, power off or transmit disable.
// - Buffer-full sets on buffer write, clears on move into shifter unless a second word waits in the buffer.
// - Shift-busy sets on move, clears at end with no next data.
// - Lighting mode: both transmit flags read zero.
// - Clock select code n picks peripheral clock over 2^n, n 0..10.
// - Rewriting clock select with same value has no effect.
// - Power off stops the prescaler and clears status and buffers.
// - Mode bit zero selects asynchronous, one lighting; resets to zero.
`timescale 1ns/1ps
`default_nettype none

module udsc_status_clock
  import udsc_pkg::*;
#(
  parameter int unsigned DW = 8
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          interface_power_bit,
  input  wire logic          receive_enable_bit,
  input  wire logic          transmit_enable_bit,
  input  wire logic          lighting_mode_select,
  input  wire logic          parity_mode_hi,
  input  wire logic          parity_mode_lo,
  input  wire logic          char_len_8,
  input  wire logic          rx_done,
  input  wire logic [DW-1:0] rx_char,
  input  wire logic          rx_parity_in,
  input  wire logic          rx_stop_in,
  input  wire logic          rx_symbol_err,
  output logic               tx_valid,
  output logic [DW-1:0]      tx_data,
  input  wire logic          tx_ready,
  input  wire logic          tx_end,
  input  wire logic [15:0]   cpu_addr,
  input  wire logic          cpu_rd,
  input  wire logic          cpu_wr,
  input  wire logic [7:0]    cpu_wdata,
  output logic [7:0]         cpu_rdata,
  output logic               cpu_rdy,
  output logic               rx_char_pending,
  output logic               base_clock_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  udsc_rd_t            rd_state_q;
  logic [7:0]          err_q;
  logic                unread_q;
  logic [DW-1:0]       async_buf_q;
  logic [DW-1:0]       light_buf_q;
  logic                busy_q;
  logic [3:0]          bcs_q;
  logic [PRESCALE_W-1:0] div_cnt_q;
  logic                tick_q;
  logic [7:0]          rdata_q;
  logic                rdy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Enables and decode
  wire rx_on  = interface_power_bit && receive_enable_bit;
  wire tx_on  = interface_power_bit && transmit_enable_bit;
  wire light  = lighting_mode_select;
  wire [1:0] par_mode = {parity_mode_hi, parity_mode_lo};

  wire rd_take    = cpu_rd && (rd_state_q == UDSC_RD_IDLE);
  wire rd_status  = rd_take && (cpu_addr == ADDR_RX_ERR_STATUS);
  wire rd_abuf    = rd_take && (cpu_addr == ADDR_ASYNC_RX_BUF);
  wire rd_lbuf    = rd_take && (cpu_addr == ADDR_LIGHT_RX_BUF);
  wire wr_bcs     = cpu_wr && (cpu_addr == ADDR_BASE_CLK_SEL);
  wire wr_txb     = cpu_wr && (cpu_addr == ADDR_TX_BUF) && tx_on;
  wire status_clr = (rd_state_q == UDSC_RD_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Receive error events
  wire [DW-1:0] char_mask = char_len_8 ? {DW{1'b1}} : {1'b0, {(DW-1){1'b1}}};
  wire par_sum  = ^(rx_char & char_mask) ^ rx_parity_in;
  // Zero parity is taken but never judged
  wire par_bad  = ((par_mode == PAR_ODD) && !par_sum) ||
                  ((par_mode == PAR_EVEN) && par_sum);
  wire rx_evt   = rx_on && rx_done;
  wire ev_mfe   = rx_evt && light && rx_symbol_err;
  wire ev_pe    = rx_evt && !light && par_bad;
  wire ev_fe    = rx_evt && !rx_stop_in;
  wire ev_ove   = rx_evt && unread_q;
  wire store    = rx_evt && !unread_q;

  wire [7:0] err_set = 8'(ev_mfe) << BIT_MFE | 8'(ev_pe) << BIT_PE |
                       8'(ev_fe) << BIT_FE | 8'(ev_ove) << BIT_OVE;
  wire [7:0] err_clr = status_clr ? err_q : 8'h00;
  // An event landing in the clear cycle survives
  wire [7:0] err_d   = rx_on ? ((err_q & ~err_clr) | err_set) : RST_RX_ERR_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // Read views, masked by mode
  wire [7:0] status_view;
  assign status_view[BIT_MFE]   = err_q[BIT_MFE] && light;
  assign status_view[6:3]       = 4'h0;
  assign status_view[BIT_PE]    = err_q[BIT_PE] && !light;
  assign status_view[BIT_FE]    = err_q[BIT_FE];
  assign status_view[BIT_OVE]   = err_q[BIT_OVE];

  wire       tx_bf      = tx_valid;
  wire [7:0] txstat_view = {6'h00, tx_bf && !light, busy_q && !light};

  wire [7:0] rd_mux =
      (cpu_addr == ADDR_TX_BUF_STATUS) ? txstat_view :
      (cpu_addr == ADDR_BASE_CLK_SEL)  ? {4'h0, bcs_q} :
      (cpu_addr == ADDR_ASYNC_RX_BUF)  ? 8'(async_buf_q) :
      (cpu_addr == ADDR_LIGHT_RX_BUF)  ? 8'(light_buf_q) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: status read costs one wait cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_state_q <= UDSC_RD_IDLE;
      rdata_q    <= 8'h00;
      rdy_q      <= 1'b0;
    end else begin
      unique case (rd_state_q)
        UDSC_RD_IDLE: begin
          rdy_q   <= cpu_rd && !rd_status;
          rdata_q <= cpu_rd ? rd_mux : 8'h00;
          if (rd_status) begin
            rd_state_q <= UDSC_RD_WAIT;
          end
        end
        UDSC_RD_WAIT: begin
          rdy_q      <= 1'b1;
          rdata_q    <= status_view;
          rd_state_q <= UDSC_RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags and receive buffers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      err_q <= RST_RX_ERR_STATUS;
    end else begin
      err_q <= err_d;
    end
  end

  // Power or receive disable empties the buffers as well
  always_ff @(posedge clock) begin
    if (!rstn || !rx_on) begin
      unread_q    <= 1'b0;
      async_buf_q <= '0;
      light_buf_q <= '0;
    end else begin
      unread_q <= store || (unread_q && !(rd_abuf || rd_lbuf));
      if (store && !light) begin
        async_buf_q <= rx_char & char_mask;
      end
      if (store && light) begin
        light_buf_q <= rx_char;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path: buffer then shifter handshake
  wire tx_in_ready;
  wire tx_take = tx_valid && tx_ready;

  udsc_skid_buf #(
    .W (DW)
  ) u_txbuf (
    .clock     (clock),
    .rstn      (rstn),
    .flush     (!tx_on),
    .in_valid  (wr_txb),
    .in_ready  (tx_in_ready),
    .in_data   (DW'(cpu_wdata)),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // Load into shifter wins over the end of the previous word
  always_ff @(posedge clock) begin
    if (!rstn || !tx_on) begin
      busy_q <= 1'b0;
    end else if (tx_take) begin
      busy_q <= 1'b1;
    end else if (tx_end) begin
      busy_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base clock select and prescaler
  // Writes always land; the counter is not restarted, so a refresh is harmless
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bcs_q <= RST_BASE_CLK_SEL;
    end else if (wr_bcs) begin
      bcs_q <= cpu_wdata[3:0];
    end
  end

  wire [PRESCALE_W-1:0] div_mask =
      PRESCALE_W'((32'h1 << bcs_q) - 32'h1);
  wire code_ok  = (bcs_q <= BCS_MAX_CODE);
  wire tick_d   = interface_power_bit && code_ok &&
                  ((div_cnt_q & div_mask) == div_mask);

  always_ff @(posedge clock) begin
    if (!rstn || !interface_power_bit) begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + PRESCALE_W'(1);
      tick_q    <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cpu_rdata       = rdata_q;
  assign cpu_rdy         = rdy_q;
  assign rx_char_pending = unread_q;
  assign base_clock_tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rx_off_clears;
    @(posedge clock) disable iff (!rstn)
    !rx_on |=> (err_q == 8'h00) && !unread_q;
  endproperty
  a_rx_off_clears: assert property (p_rx_off_clears)
    else $error("error status not cleared while receive off");

  property p_read_clears;
    @(posedge clock) disable iff (!rstn)
    (rd_status && rx_on) ##1 (!rx_done && rx_on) |=> (err_q == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("error flags survived a status read");

  property p_status_wait;
    @(posedge clock) disable iff (!rstn)
    rd_status |=> !cpu_rdy ##1 cpu_rdy;
  endproperty
  a_status_wait: assert property (p_status_wait)
    else $error("status read did not take exactly one wait cycle");

  property p_mode_masks;
    @(posedge clock) disable iff (!rstn)
    ((rd_state_q == UDSC_RD_WAIT) && light |=> !cpu_rdata[BIT_PE]) and
    ((rd_state_q == UDSC_RD_WAIT) && !light |=> !cpu_rdata[BIT_MFE]);
  endproperty
  a_mode_masks: assert property (p_mode_masks)
    else $error("inactive error flag visible");

  property p_mfe_set;
    @(posedge clock) disable iff (!rstn)
    rx_on && light && rx_done && rx_symbol_err ##1 rx_on |-> err_q[BIT_MFE];
  endproperty
  a_mfe_set: assert property (p_mfe_set)
    else $error("Manchester error not flagged");

  property p_pe_set;
    @(posedge clock) disable iff (!rstn)
    rx_on && !light && rx_done && char_len_8 && (par_mode == PAR_EVEN) &&
    (^{rx_char, rx_parity_in}) ##1 rx_on |-> err_q[BIT_PE];
  endproperty
  a_pe_set: assert property (p_pe_set)
    else $error("even parity mismatch not flagged");

  property p_fe_set;
    @(posedge clock) disable iff (!rstn)
    rx_on && rx_done && !rx_stop_in ##1 rx_on |-> err_q[BIT_FE];
  endproperty
  a_fe_set: assert property (p_fe_set)
    else $error("missing stop bit not flagged");

  property p_overrun;
    @(posedge clock) disable iff (!rstn)
    rx_on && rx_done && unread_q ##1 rx_on |->
      err_q[BIT_OVE] && $stable(async_buf_q) && $stable(light_buf_q);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or buffer overwritten");

  property p_tx_off;
    @(posedge clock) disable iff (!rstn)
    !tx_on |=> !busy_q && !tx_valid;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmit status not cleared");

  property p_bf_set;
    @(posedge clock) disable iff (!rstn)
    wr_txb && tx_in_ready && !tx_valid ##1 tx_on |-> tx_valid;
  endproperty
  a_bf_set: assert property (p_bf_set)
    else $error("buffer-full not set after write");

  property p_busy;
    @(posedge clock) disable iff (!rstn)
    tx_take ##1 tx_on |-> busy_q;
  endproperty
  a_busy: assert property (p_busy)
    else $error("shift-busy not set on load");

  property p_tick;
    @(posedge clock) disable iff (!rstn)
    interface_power_bit && (bcs_q == 4'h0) |=> base_clock_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("undivided base clock missed a tick");

  property p_bad_code;
    @(posedge clock) disable iff (!rstn)
    (bcs_q > BCS_MAX_CODE) |=> !base_clock_tick;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("prohibited code produced a tick");

endmodule // udsc_status_clock

`default_nettype wire

// >>> bench/udsc_far_node.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side: hands over finished characters and plays the transmit shifter
module udsc_far_node (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       stall,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            tx_end,
  output logic            rx_done,
  output logic [7:0]      rx_char,
  output logic            rx_parity_in,
  output logic            rx_stop_in,
  output logic            rx_symbol_err
);
  localparam int SHIFT_CYC = 20;
  int         cnt = 0;
  logic [7:0] got[$];

  // One word in the shifter at a time, as a real shift register holds
  assign tx_ready = !stall && cnt == 0;

  initial begin
    tx_end = 1'b0;
    rx_done = 1'b0;
    rx_char = 8'h00;
    rx_parity_in = 1'b1;
    rx_stop_in = 1'b1;
    rx_symbol_err = 1'b0;
  end

  always @(posedge clock) begin
    tx_end <= 1'b0;
    if (!rstn) begin
      cnt <= 0;
    end else if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      cnt <= SHIFT_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      tx_end <= (cnt == 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Only the first stop bit is reported
  task automatic send(input logic [7:0] c, input logic p, input logic st, input logic sy);
    @(posedge clock);
    rx_done <= 1'b1;
    rx_char <= c;
    rx_parity_in <= p;
    rx_stop_in <= st;
    rx_symbol_err <= sy;
    @(posedge clock);
    rx_done <= 1'b0;
    // Stale lines show the inverse so that nothing matches by luck
    rx_char <= ~c;
    rx_parity_in <= ~p;
    rx_stop_in <= ~st;
    rx_symbol_err <= ~sy;
  endtask
endmodule // udsc_far_node
`default_nettype wire

// >>> bench/udsc_status_clock_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module udsc_status_clock_tb_top
  import udsc_pkg::*;
;
  logic        clock, rstn, pwr, rxe, txe, light, ph, pl, len8, stall;
  logic        cpu_rd, cpu_wr, cpu_rdy, pend, tick, p, s, y;
  logic        tx_valid, tx_ready, tx_end, rx_done, rx_par, rx_stop, rx_sym;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, tx_data, rx_char, c, a, d, m8;
  logic [7:0]  w[3];
  int          fails, check_count, cyc, i, per;
  int          codes[4] = '{0, 1, 2, 10};

  udsc_status_clock #(.DW(8)) u_dut (
    .clock(clock), .rstn(rstn), .interface_power_bit(pwr), .receive_enable_bit(rxe),
    .transmit_enable_bit(txe), .lighting_mode_select(light), .parity_mode_hi(ph),
    .parity_mode_lo(pl), .char_len_8(len8), .rx_done(rx_done), .rx_char(rx_char),
    .rx_parity_in(rx_par), .rx_stop_in(rx_stop), .rx_symbol_err(rx_sym),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_end(tx_end),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rdy(cpu_rdy), .rx_char_pending(pend), .base_clock_tick(tick)
  );
  udsc_far_node u_far (
    .clock(clock), .rstn(rstn), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_end(tx_end), .rx_done(rx_done), .rx_char(rx_char),
    .rx_parity_in(rx_par), .rx_stop_in(rx_stop), .rx_symbol_err(rx_sym)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // A hang costs a mismatch rather than a silent stall
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic pe_exp(input logic [7:0] ch, input logic pb, input logic [1:0] m);
    if (m == PAR_ODD) return (^ch ^ pb) != 1'b1;
    if (m == PAR_EVEN) return (^ch ^ pb) != 1'b0;
    return 1'b0;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [15:0] ad, input logic [7:0] v);
    @(posedge clock);
    cpu_addr <= ad;
    cpu_wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
  endtask

  task rd(input logic [15:0] ad, output logic [7:0] v);
    int k;
    k = 0;
    @(posedge clock);
    cpu_addr <= ad;
    cpu_rd <= 1'b1;
    @(posedge clock);
    cpu_rd <= 1'b0;
    #1;
    while (cpu_rdy !== 1'b1 && k < 4) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk(k, (ad == ADDR_RX_ERR_STATUS) ? 1 : 0);
    v = cpu_rdata;
  endtask

  task pw(input logic lm);
    @(posedge clock);
    pwr <= 1'b0;
    rxe <= 1'b0;
    txe <= 1'b0;
    @(posedge clock);
    light <= lm;
    pwr <= 1'b1;
    @(posedge clock);
    rxe <= 1'b1;
    txe <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task period(output int pr);
    int k;
    k = 0;
    @(posedge clock);
    #1;
    while (tick !== 1'b1 && k < 3000) begin
      @(posedge clock);
      #1;
      k++;
    end
    pr = 1;
    @(posedge clock);
    #1;
    while (tick !== 1'b1 && pr < 3000) begin
      @(posedge clock);
      #1;
      pr++;
    end
  endtask

  task test_done();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, pwr, rxe, txe, light, ph, pl, len8, stall, cpu_rd, cpu_wr} = 11'h000;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    {fails, check_count, cyc} = '0;
    void'($urandom(32'h8eb7));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(ADDR_RX_ERR_STATUS, d);
    chk(d, RST_RX_ERR_STATUS);
    rd(ADDR_TX_BUF_STATUS, d);
    chk(d, RST_TX_BUF_STATUS);
    rd(ADDR_BASE_CLK_SEL, d);
    chk(d, {4'h0, RST_BASE_CLK_SEL});
    rd(16'hff00, d);
    chk(d, 8'h00);
    wr(ADDR_BASE_CLK_SEL, 8'hf3);
    rd(ADDR_BASE_CLK_SEL, d);
    chk(d, 8'h03);
    $display("test reset done");
    pw(1'b0);
    for (i = 0; i < 8; i++) begin
      {c, p, s, y} = 11'($urandom);
      m8 = i[2] ? 8'h7f : 8'hff;
      {ph, pl} <= 2'(i);
      len8 <= !i[2];
      u_far.send(c, p, s, y);
      rd(ADDR_RX_ERR_STATUS, d);
      chk(d, {5'h00, pe_exp(c & m8, p, 2'(i)), ~s, 1'b0});
      rd(ADDR_ASYNC_RX_BUF, d);
      chk(d, c & m8);
      chk(pend, 1'b0);
      rd(ADDR_RX_ERR_STATUS, d);
      chk(d, 8'h00);
    end
    {ph, pl} <= PAR_NONE;
    len8 <= 1'b1;
    c = 8'($urandom);
    a = ~c;
    u_far.send(c, 1'b0, 1'b1, 1'b0);
    u_far.send(a, 1'b0, 1'b1, 1'b0);
    rd(ADDR_RX_ERR_STATUS, d);
    chk(d, 8'h01);
    rd(ADDR_ASYNC_RX_BUF, d);
    chk(d, c);
    $display("test async receive done");
    pw(1'b1);
    {ph, pl} <= PAR_EVEN;
    len8 <= 1'b0;
    for (i = 0; i < 4; i++) begin
      {c, p, s, y} = 11'($urandom);
      u_far.send(c, p, s, y);
      rd(ADDR_RX_ERR_STATUS, d);
      chk(d, {y, 4'h0, 1'b0, ~s, 1'b0});
      rd(ADDR_LIGHT_RX_BUF, d);
      chk(d, c);
    end
    wr(ADDR_TX_BUF, c);
    rd(ADDR_TX_BUF_STATUS, d);
    chk(d, 8'h00);
    $display("test lighting done");
    pw(1'b0);
    // The lighting word may still be shifting; start from an idle shifter
    i = 0;
    while (u_far.cnt != 0 && i < 40) begin
      @(posedge clock);
      i++;
    end
    u_far.got.delete();
    stall <= 1'b1;
    for (i = 0; i < 3; i++) begin
      w[i] = 8'($urandom);
      // Third write meets a full two-entry buffer and must be dropped
      wr(ADDR_TX_BUF, w[i]);
      if (i == 0) begin
        rd(ADDR_TX_BUF_STATUS, d);
        chk(d, 8'h02);
      end
    end
    #1;
    chk(tx_valid, 1'b1);
    chk(tx_data, w[0]);
    stall <= 1'b0;
    repeat (5) @(posedge clock);
    rd(ADDR_TX_BUF_STATUS, d);
    chk(d, 8'h03);
    i = 0;
    while (u_far.got.size() < 2 && i < 200) begin
      @(posedge clock);
      i++;
    end
    repeat (30) @(posedge clock);
    rd(ADDR_TX_BUF_STATUS, d);
    chk(d, 8'h00);
    chk(u_far.got.size(), 2);
    chk(u_far.got[0], w[0]);
    chk(u_far.got[1], w[1]);
    stall <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(ADDR_TX_BUF, w[2]);
      u_far.send(w[2], 1'b0, 1'b0, 1'b1);
      if (i == 0) {txe, rxe} <= 2'b00;
      else pwr <= 1'b0;
      @(posedge clock);
      {pwr, txe, rxe} <= 3'b111;
      repeat (2) @(posedge clock);
      rd(ADDR_TX_BUF_STATUS, d);
      chk(d, RST_TX_BUF_STATUS);
      chk(tx_valid, 1'b0);
      rd(ADDR_RX_ERR_STATUS, d);
      chk(d, RST_RX_ERR_STATUS);
      if (i == 1) chk(pend, 1'b0);
    end
    stall <= 1'b0;
    $display("test transmit done");
    foreach (codes[k]) begin
      pwr <= 1'b0;
      wr(ADDR_BASE_CLK_SEL, 8'(codes[k]));
      pwr <= 1'b1;
      period(per);
      chk(per, 1 << codes[k]);
      wr(ADDR_BASE_CLK_SEL, 8'(codes[k]));
      period(per);
      chk(per, 1 << codes[k]);
    end
    pwr <= 1'b0;
    wr(ADDR_BASE_CLK_SEL, 8'h0b);
    pwr <= 1'b1;
    per = 0;
    repeat (64) begin
      @(posedge clock);
      #1;
      if (tick === 1'b1) per++;
    end
    chk(per, 0);
    $display("test base clock done");
    test_done();
  end
endmodule // udsc_status_clock_tb_top
`default_nettype wire
